// *** busy_load_update_sequencer.sv ***
// Purpose: Device end: frame capture, busy timing, calibration engine,
//          deferred load of outputs and modes.
// Assumes: Link pins are asynchronous and pass two flip-flops.
// Notes:   Busy is only ever driven low; the line is shared.
//
// Behaviour
// [R1] Every write holds busy low until done
// [R2] Input write computes cached value under busy
// [R3] Host ends frame only after busy high
// [R4] Output changes only after selecting control write
// [R5] Low load applies pending outputs and modes
// [R6] Load during busy applied once busy high
// [R7] Load tied low applies at each release
// [R8] Open-drain busy; wait while others hold
// [R9] One engine serves channels in turn
// [R10] Input write busy within (n+1)*650+350 ns
// [R11] Control write or readback busy 270 ns
// [R12] Host times writes or waits for busy
// [R13] Busy low in reset and reset fall
// [R14] Control, gain, offset writes skip engine; control writes that change range, compare or force kind still use it here
// [R15] Short control bits give 270 ns busy
// [R16] Range or compare change engages engine
// [R17] Same-kind force swaps short, others engine
// [R18] Three stages 650, 650, 350 ns
// [R19] Host spaces frame ends by 650 ns
// [R20] Frame taken at select rise, 29 bits
// [R21] Both select bits mean input value write
`timescale 1ns/10ps
module busy_load_update_sequencer #(
   parameter int RESET_CYCLES = busy_load_pkg::RESET_CYC
) (
   input  wire logic                     mclk,
   input  wire logic                     rstn,
   input  wire logic                     devResetN,
   busy_load_if.device                   link,
   output busy_load_pkg::dac_type [3:0]  dacOut,
   output busy_load_pkg::pmu_word_type [3:0] pmuMode,
   output logic                          applyPulse,
   output logic                          calibActive
);

   localparam int N = busy_load_pkg::NCH;

   logic [5:0]                          syncA;
   logic [5:0]                          syncB;
   logic                                sclkS;
   logic                                sdiS;
   logic                                frameS;
   logic                                loadS;
   logic                                lineS;
   logic                                rstPinS;
   logic                                sclkPrev;
   logic                                framePrev;
   logic                                rstPrev;
   logic                                sclkFall;
   logic                                frameRise;
   logic                                pinFall;
   logic [busy_load_pkg::WORD_BITS-1:0] shiftWord;
   logic [4:0]                          bitCnt;
   logic                                cmdStrobe;
   logic                                chanWrite;
   logic [N-1:0]                        chMask;
   busy_load_pkg::register_set_sel_type sel;
   busy_load_pkg::pmu_word_type         data;
   logic [N-1:0]                        calMask;
   logic [N-1:0]                        pmuWriteMask;
   logic                                shortStart;
   busy_load_pkg::dac_type              dacIn   [N];
   busy_load_pkg::dac_type              gain    [N];
   busy_load_pkg::dac_type              offset  [N];
   busy_load_pkg::dac_type              hold    [N];
   busy_load_pkg::dac_type              cached  [N];
   busy_load_pkg::pmu_word_type         pmuPend [N];
   logic [N-1:0]                        armed;
   busy_load_pkg::engine_state_type     engState;
   logic [15:0]                         engTimer;
   logic [1:0]                          curCh;
   logic [1:0]                          nextCh;
   logic [N-1:0]                        pending;
   logic [N-1:0]                        pendNow;
   logic [N-1:0]                        take;
   logic [N-1:0]                        batch;
   logic                                stage1End;
   logic [15:0]                         shortCnt;
   logic [15:0]                         resetCnt;
   logic                                resetting;
   logic                                holdLow;
   logic                                loadReq;
   logic                                apply;
   logic [32:0]                         scaled;

   function automatic logic [1:0] lowest_ch(logic [N-1:0] m);
      logic [1:0] idx;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (m[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction : lowest_ch

   // Pins from the other party are asynchronous
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         syncA <= '1;
         syncB <= '1;
      end else begin
         syncA <= {link.sclk, link.sdi, link.frameSelN, link.loadN,
                   link.busyLine, devResetN};
         syncB <= syncA;
      end
   end

   assign {sclkS, sdiS, frameS, loadS, lineS, rstPinS} = syncB;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sclkPrev  <= 1'b1;
         framePrev <= 1'b1;
         rstPrev   <= 1'b1;
      end else begin
         sclkPrev  <= sclkS;
         framePrev <= frameS;
         rstPrev   <= rstPinS;
      end
   end

   assign sclkFall  = sclkPrev & ~sclkS;
   assign frameRise = frameS & ~framePrev;
   assign pinFall   = rstPrev & ~rstPinS;

   // Frame shifter; longer frames keep the last 29 bits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shiftWord <= '0;
         bitCnt    <= '0;
      end else if (frameS) begin
         bitCnt <= '0;
      end else if (sclkFall) begin
         shiftWord <= {shiftWord[busy_load_pkg::WORD_BITS-2:0], sdiS};
         if (bitCnt < 5'(busy_load_pkg::WORD_BITS)) begin
            bitCnt <= bitCnt + 5'h1;
         end
      end
   end

   // While resetting, all frames are ignored
   assign cmdStrobe = frameRise & ~resetting
                    & (bitCnt >= 5'(busy_load_pkg::WORD_BITS)); // [R20]
   assign chMask    = shiftWord[busy_load_pkg::CH_MSB:busy_load_pkg::CH_LSB];
   assign sel       = busy_load_pkg::register_set_sel_type'(
      shiftWord[busy_load_pkg::SEL_MSB:busy_load_pkg::SEL_LSB]);
   assign data      = shiftWord[busy_load_pkg::DATA_MSB:0];
   assign chanWrite = cmdStrobe & ~shiftWord[busy_load_pkg::RW_BIT]
                    & (|chMask);

   always_comb begin
      for (int i = 0; i < N; i++) begin
         calMask[i] = chanWrite & chMask[i]
            & ((sel == busy_load_pkg::SEL_DAC) // [R21] [R2]
              | ((sel == busy_load_pkg::SEL_PMU) // [R16] [R17]
                & busy_load_pkg::pmu_needs_calib(pmuPend[i], data)));
         pmuWriteMask[i] = chanWrite & chMask[i]
                         & (sel == busy_load_pkg::SEL_PMU);
      end
   end

   // Gain, offset, readback and short control bits skip the engine
   assign shortStart = cmdStrobe & ~(|calMask); // [R14] [R15] [R11]

   // Input, coefficient and control-word storage
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < N; i++) begin
            dacIn[i]   <= '0;
            gain[i]    <= busy_load_pkg::GAIN_RST;
            offset[i]  <= busy_load_pkg::OFFSET_RST;
            pmuPend[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (pinFall) begin
               dacIn[i]   <= '0;
               gain[i]    <= busy_load_pkg::GAIN_RST;
               offset[i]  <= busy_load_pkg::OFFSET_RST;
               pmuPend[i] <= '0;
            end else if (chanWrite && chMask[i]) begin
               unique case (sel)
                  busy_load_pkg::SEL_PMU:
                     pmuPend[i] <= data;
                  busy_load_pkg::SEL_GAIN:
                     gain[i] <= data[busy_load_pkg::DAC_MSB:0];
                  busy_load_pkg::SEL_OFFSET:
                     offset[i] <= data[busy_load_pkg::DAC_MSB:0];
                  busy_load_pkg::SEL_DAC:
                     dacIn[i] <= data[busy_load_pkg::DAC_MSB:0];
               endcase
            end
         end
      end
   end

   // Shared engine: stage one per channel in turn, then the last
   // channel's stages two and three; earlier channels overlap.
   assign pendNow   = pending | calMask;
   assign nextCh    = lowest_ch(pendNow);
   assign stage1End = (engState == busy_load_pkg::ENG_STAGE1)
                    & (engTimer == '0);

   always_comb begin
      take = '0;
      if (((engState == busy_load_pkg::ENG_IDLE) || stage1End)
          && (|pendNow)) begin
         take[nextCh] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         engState <= busy_load_pkg::ENG_IDLE;
         engTimer <= '0;
         curCh    <= '0;
         pending  <= '0;
         batch    <= '0;
      end else if (pinFall) begin
         engState <= busy_load_pkg::ENG_IDLE;
         engTimer <= '0;
         pending  <= '0;
         batch    <= '0;
      end else begin
         // A take starts the pass that reads the new value at the end of
         // stage one, so a write in its own take cycle needs no rerun
         pending <= (pending | calMask) & ~take; // [R9]
         unique case (engState)
            busy_load_pkg::ENG_IDLE: begin
               if (|pendNow) begin
                  engState <= busy_load_pkg::ENG_STAGE1;
                  engTimer <= busy_load_pkg::STAGE1_LOAD; // [R18]
                  curCh    <= nextCh;
                  batch    <= '0;
               end
            end
            busy_load_pkg::ENG_STAGE1: begin
               if (engTimer == '0) begin
                  batch[curCh] <= 1'b1;
                  if (|pendNow) begin
                     engTimer <= busy_load_pkg::STAGE1_LOAD; // [R9] [R10]
                     curCh    <= nextCh;
                  end else begin
                     engState <= busy_load_pkg::ENG_STAGE2;
                     engTimer <= busy_load_pkg::STAGE2_LOAD; // [R18]
                  end
               end else begin
                  engTimer <= engTimer - 16'h1;
               end
            end
            busy_load_pkg::ENG_STAGE2: begin
               if (engTimer == '0) begin
                  engState <= busy_load_pkg::ENG_STAGE3;
                  engTimer <= busy_load_pkg::STAGE3_LOAD; // [R18]
               end else begin
                  engTimer <= engTimer - 16'h1;
               end
            end
            busy_load_pkg::ENG_STAGE3: begin
               if (engTimer == '0) begin
                  engState <= busy_load_pkg::ENG_IDLE;
               end else begin
                  engTimer <= engTimer - 16'h1;
               end
            end
         endcase
      end
   end

   // Gain scaling at stage one; offset added when the batch commits
   assign scaled = 33'(dacIn[curCh]) * (33'(gain[curCh]) + 33'h1);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < N; i++) begin
            hold[i]   <= '0;
            cached[i] <= '0;
         end
      end else begin
         if (stage1End) begin
            hold[curCh] <= scaled[31:16];
         end
         if ((engState == busy_load_pkg::ENG_STAGE3) && (engTimer == '0)) begin
            for (int i = 0; i < N; i++) begin
               if (batch[i]) begin
                  cached[i] <= hold[i] + offset[i]
                             - busy_load_pkg::MIDSCALE; // [R2]
               end
            end
         end
      end
   end

   // Short busy for writes that do not use the engine
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shortCnt <= '0;
      end else if (shortStart) begin
         shortCnt <= busy_load_pkg::SHORT_LOAD; // [R11] [R15]
      end else if (shortCnt != '0) begin
         shortCnt <= shortCnt - 16'h1;
      end
   end

   // Power-on and pin reset both run the initialisation time
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         resetCnt <= 16'(RESET_CYCLES);
      end else if (pinFall || !rstPinS) begin
         resetCnt <= 16'(RESET_CYCLES); // [R13]
      end else if (resetCnt != '0) begin
         resetCnt <= resetCnt - 16'h1;
      end
   end

   assign resetting = (resetCnt != '0) | ~rstPinS;
   assign holdLow   = resetting | cmdStrobe | (shortCnt != '0)
                    | (engState != busy_load_pkg::ENG_IDLE)
                    | (|pending); // [R1] [R13]

   // Busy is driven low from reset on; only ever released, never driven high
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         link.busyOeN <= 1'b0; // [R13]
      end else begin
         link.busyOeN <= ~holdLow; // [R8]
      end
   end

   assign link.busyOut = 1'b0; // [R8]

   // Shared line must be high too, so the slowest device gates the load
   assign apply = loadReq & lineS & ~holdLow; // [R6] [R8]

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         loadReq <= 1'b0;
      end else begin
         // Low level sets, wins over the clear by apply
         loadReq <= (loadReq & ~apply) | ~loadS; // [R5] [R6] [R7]
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         armed <= '0;
      end else if (pinFall) begin
         armed <= '0;
      end else begin
         armed <= (armed & ~{N{apply}}) | pmuWriteMask; // [R4]
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dacOut     <= '0;
         pmuMode    <= '0;
         applyPulse <= 1'b0;
      end else begin
         applyPulse <= apply;
         if (apply) begin
            for (int i = 0; i < N; i++) begin
               pmuMode[i] <= pmuPend[i]; // [R5]
               if (armed[i]) begin
                  dacOut[i] <= cached[i]; // [R4]
               end
            end
         end
      end
   end

   assign calibActive = (engState != busy_load_pkg::ENG_IDLE);

endmodule : busy_load_update_sequencer

// *** busy_load_pkg.sv ***
// Purpose: Shared constants and types for the busy/load update sequencer.
// Assumes: 25 MHz mclk; 29-bit serial frames, MSB first.
// Notes:   Longest times round down, least times round up, floor of one.
package busy_load_pkg;

   localparam int CLK_NS     = 40;
   localparam int NCH        = 4;
   localparam int WORD_BITS  = 29;

   // Frame field positions
   localparam int RW_BIT     = 28;
   localparam int CH_MSB     = 27;
   localparam int CH_LSB     = 24;
   localparam int SEL_MSB    = 23;
   localparam int SEL_LSB    = 22;
   localparam int DATA_MSB   = 21;
   localparam int DAC_MSB    = 15;

   // Channel-control field positions
   localparam int FORCE_LSB  = 19;
   localparam int RANGE_MSB  = 17;
   localparam int RANGE_LSB  = 15;
   localparam int CMPQ_BIT   = 7;

   // Times as printed
   localparam int STAGE1_NS  = 650;
   localparam int STAGE2_NS  = 650;
   localparam int STAGE3_NS  = 350;
   localparam int SHORT_NS   = 270;
   localparam int GAP_NS     = 650;
   localparam int RESET_NS   = 600000;

   // Longest times: round down
   localparam int STAGE1_CYC =
      (STAGE1_NS / CLK_NS < 1) ? 1 : STAGE1_NS / CLK_NS;
   localparam int STAGE2_CYC =
      (STAGE2_NS / CLK_NS < 1) ? 1 : STAGE2_NS / CLK_NS;
   localparam int STAGE3_CYC =
      (STAGE3_NS / CLK_NS < 1) ? 1 : STAGE3_NS / CLK_NS;
   localparam int SHORT_CYC  =
      (SHORT_NS / CLK_NS < 1) ? 1 : SHORT_NS / CLK_NS;
   localparam int RESET_CYC  = RESET_NS / CLK_NS;
   // Least time: round up
   localparam int GAP_CYC    = (GAP_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [15:0] STAGE1_LOAD = 16'(STAGE1_CYC - 1);
   localparam logic [15:0] STAGE2_LOAD = 16'(STAGE2_CYC - 1);
   localparam logic [15:0] STAGE3_LOAD = 16'(STAGE3_CYC - 1);
   localparam logic [15:0] SHORT_LOAD  = 16'(SHORT_CYC - 1);
   localparam logic [15:0] GAP_LOAD    = 16'(GAP_CYC);

   // Host serial pacing, in mclk cycles
   localparam logic [3:0]  SCLK_HALF   = 4'h4;
   localparam logic [3:0]  FRAME_HIGH  = 4'h4;

   // Reset contents
   localparam logic [15:0] GAIN_RST    = 16'hffff;
   localparam logic [15:0] OFFSET_RST  = 16'h8000;
   localparam logic [15:0] MIDSCALE    = 16'h8000;

   typedef logic [15:0] dac_type;
   typedef logic [21:0] pmu_word_type;

   typedef enum logic [1:0] {
      SEL_PMU    = 2'b00,
      SEL_GAIN   = 2'b01,
      SEL_OFFSET = 2'b10,
      SEL_DAC    = 2'b11
   } register_set_sel_type;

   typedef enum logic [1:0] {
      ENG_IDLE   = 2'b00,
      ENG_STAGE1 = 2'b01,
      ENG_STAGE2 = 2'b10,
      ENG_STAGE3 = 2'b11
   } engine_state_type;

   typedef enum logic [1:0] {
      HOST_IDLE  = 2'b00,
      HOST_SHIFT = 2'b01,
      HOST_WAIT  = 2'b10,
      HOST_END   = 2'b11
   } host_state_type;

   // Force swaps that keep bit 0 (voltage/current kind) are short
   function automatic logic pmu_needs_calib(pmu_word_type oldW,
                                            pmu_word_type newW);
      return (oldW[RANGE_MSB:RANGE_LSB] != newW[RANGE_MSB:RANGE_LSB])
           | (oldW[CMPQ_BIT] != newW[CMPQ_BIT])
           | (oldW[FORCE_LSB] != newW[FORCE_LSB]);
   endfunction : pmu_needs_calib

endpackage : busy_load_pkg

// *** busy_load_if.sv ***
// Purpose: Serial frame, load strobe and wired-AND busy line.
// Assumes: Device drives busy open-drain; pull-up modelled here.
// Notes:   otherHoldN stands for further devices on the line.
`timescale 1ns/10ps
interface busy_load_if;
   logic sclk;
   logic sdi;
   logic frameSelN;
   logic loadN;
   logic busyOut;
   logic busyOeN;
   logic otherHoldN;
   logic busyLine;

   // Wired AND with pull-up
   assign busyLine = (busyOeN | busyOut) & otherHoldN;

   modport device (
      input  sclk,
      input  sdi,
      input  frameSelN,
      input  loadN,
      input  busyLine,
      output busyOut,
      output busyOeN
   );

   modport host (
      output sclk,
      output sdi,
      output frameSelN,
      output loadN,
      input  busyLine
   );
endinterface : busy_load_if

// *** host_update_driver.sv ***
// Purpose: Host end: shifts 29-bit frames, drives load, watches busy.
// Assumes: One command at a time from the user side.
// Notes:   Frames are held open until busy is high, so no write is lost.
`timescale 1ns/10ps
module host_update_driver (
   input  wire logic                                mclk,
   input  wire logic                                rstn,
   busy_load_if.host                                link,
   input  wire logic                                cmdValid,
   input  wire logic [busy_load_pkg::WORD_BITS-1:0] cmdWord,
   output logic                                     cmdReady,
   input  wire logic                                applyHold,
   output logic                                     frameDone,
   output logic                                     busySeen
);

   busy_load_pkg::host_state_type       state;
   logic [busy_load_pkg::WORD_BITS-1:0] word;
   logic [4:0]                          bitIdx;
   logic [3:0]                          phase;
   logic [15:0]                         gapCnt;
   logic                                busyA;
   logic                                busyB;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busyA <= 1'b0;
         busyB <= 1'b0;
      end else begin
         busyA <= link.busyLine;
         busyB <= busyA;
      end
   end

   assign busySeen = busyB;
   // Spacing also covers the device's delay in pulling busy low
   assign cmdReady = (state == busy_load_pkg::HOST_IDLE)
                   & (gapCnt == '0); // [R12] [R19]

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         link.loadN <= 1'b1;
      end else begin
         link.loadN <= ~applyHold; // [R7]
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state          <= busy_load_pkg::HOST_IDLE;
         word           <= '0;
         bitIdx         <= '0;
         phase          <= '0;
         gapCnt         <= '0;
         frameDone      <= 1'b0;
         link.sclk      <= 1'b1;
         link.sdi       <= 1'b0;
         link.frameSelN <= 1'b1;
      end else begin
         frameDone <= 1'b0;
         if (gapCnt != '0) begin
            gapCnt <= gapCnt - 16'h1;
         end
         unique case (state)
            busy_load_pkg::HOST_IDLE: begin
               if (cmdValid && cmdReady) begin
                  word           <= cmdWord;
                  bitIdx         <= 5'(busy_load_pkg::WORD_BITS - 1);
                  link.sdi       <= cmdWord[busy_load_pkg::WORD_BITS-1];
                  link.sclk      <= 1'b1;
                  link.frameSelN <= 1'b0;
                  phase          <= busy_load_pkg::SCLK_HALF;
                  state          <= busy_load_pkg::HOST_SHIFT;
               end
            end
            busy_load_pkg::HOST_SHIFT: begin
               if (phase != '0) begin
                  phase <= phase - 4'h1;
               end else if (link.sclk) begin
                  link.sclk <= 1'b0;
                  phase     <= busy_load_pkg::SCLK_HALF;
               end else if (bitIdx == '0) begin
                  link.sclk <= 1'b1;
                  state     <= busy_load_pkg::HOST_WAIT;
               end else begin
                  link.sclk <= 1'b1;
                  link.sdi  <= word[bitIdx - 5'h1];
                  bitIdx    <= bitIdx - 5'h1;
                  phase     <= busy_load_pkg::SCLK_HALF;
               end
            end
            busy_load_pkg::HOST_WAIT: begin
               if (busyB && (gapCnt == '0)) begin
                  link.frameSelN <= 1'b1; // [R3] [R19]
                  frameDone      <= 1'b1;
                  gapCnt         <= busy_load_pkg::GAP_LOAD; // [R12]
                  phase          <= busy_load_pkg::FRAME_HIGH;
                  state          <= busy_load_pkg::HOST_END;
               end
            end
            busy_load_pkg::HOST_END: begin
               if (phase != '0) begin
                  phase <= phase - 4'h1;
               end else begin
                  state <= busy_load_pkg::HOST_IDLE;
               end
            end
         endcase
      end
   end

endmodule : host_update_driver

// *** busy_load_asserts.sv ***
// Purpose: Link and apply checks beside the joined ends
// Assumes: One clock; RESET_CYCLES of 20
// Notes:   A counter bounds busy, as long repeats stall tools
`timescale 1ns/10ps
module busy_load_asserts (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic frameSelN,
   input wire logic loadN,
   input wire logic busyOut,
   input wire logic busyOeN,
   input wire logic busyLine,
   input wire logic applyPulse
);
   int lowCnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence sFree;
      (busyLine && !loadN) [*6];
   endsequence
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) lowCnt <= 0;
      else lowCnt <= busyOeN ? 0 : lowCnt + 1;
   end
   chk_pin_low_only: assert property (busyOut == 1'h0)
      else $error("busy pin driven high");
   chk_frame_busy: assert property
      ($rose(frameSelN) |-> ##[3:5] !busyOeN) else $error("no busy");
   chk_end_when_free: assert property
      ($rose(frameSelN) |-> $past(busyLine)) else $error("ended in busy");
   chk_gap_kept: assert property
      ($rose(frameSelN) |=> frameSelN [*8]) else $error("frames close");
   chk_busy_bound: assert property (lowCnt <= 90)
      else $error("busy too long");
   chk_reset_hold: assert property
      ($rose(rstn) |-> !busyOeN [*8]) else $error("busy not in reset");
   chk_apply_held: assert property
      (!busyLine [*4] |=> !applyPulse) else $error("applied in busy");
   chk_tied_load: assert property
      (sFree |-> ##[0:6] applyPulse) else $error("load not applied");
endmodule : busy_load_asserts

// *** test_busy_load_update_sequencer.sv ***
// Purpose: Joins both ends; busy widths, deferred and shared load
// Assumes: RESET_CYCLES of 20 keeps the run short
// Notes:   Widths count cycles of the device enable low
`timescale 1ns/10ps
module test_busy_load_update_sequencer;
   logic        mclk = 1'h0;
   logic        rstn = 1'h0;
   logic        cmdValid = 1'h0;
   logic        applyHold = 1'h0;
   logic        cmdReady;
   logic        frameDone;
   logic        applyPulse;
   logic        calibActive;
   logic        busySeen;
   logic        devResetN = 1'h1;
   bit          calSeen;
   logic [28:0] cmdWord = 29'h0;
   int          badCount = 0;
   int          compares = 0;
   int          cyc = 0;
   int          width;
   busy_load_pkg::dac_type [3:0]      dacOut;
   busy_load_pkg::pmu_word_type [3:0] pmuMode;
   busy_load_if link ();
   busy_load_update_sequencer #(.RESET_CYCLES(20))
      i_busy_load_update_sequencer (.mclk(mclk), .rstn(rstn),
      .devResetN(devResetN), .link(link), .dacOut(dacOut), .pmuMode(pmuMode),
      .applyPulse(applyPulse), .calibActive(calibActive));
   host_update_driver i_host_update_driver (.mclk(mclk), .rstn(rstn),
      .link(link), .cmdValid(cmdValid), .cmdWord(cmdWord),
      .cmdReady(cmdReady), .applyHold(applyHold),
      .frameDone(frameDone), .busySeen(busySeen));
   busy_load_asserts i_busy_load_asserts (.mclk(mclk), .rstn(rstn),
      .frameSelN(link.frameSelN), .loadN(link.loadN),
      .busyOut(link.busyOut), .busyOeN(link.busyOeN),
      .busyLine(link.busyLine), .applyPulse(applyPulse));
   initial begin
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         badCount++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // Load and far hold change only once busy is seen, never before it
   task automatic send(input logic [28:0] w, input logic ld, hold);
      @(posedge mclk iff cmdReady);
      cmdValid <= 1'h1;
      cmdWord <= w;
      @(posedge mclk);
      cmdValid <= 1'h0;
      @(posedge mclk iff frameDone);
      @(posedge mclk iff !link.busyOeN);
      applyHold <= ld;
      link.otherHoldN <= hold;
      width = 0;
      calSeen = 1'b0;
      while (!link.busyOeN) begin
         @(posedge mclk);
         width++;
         calSeen |= calibActive;
      end
   endtask : send
   task automatic t_modes;
      logic [28:0] w [8] = '{29'h1200000, 29'h1300000, 29'h1380000,
         29'h1388000, 29'h1388080, 29'h0, 29'h140ffff, 29'h10000000};
      bit lng [8] = '{0, 0, 1, 1, 1, 0, 0, 0};
      foreach (w[i]) begin
         send(w[i], 1'h0, 1'h1);
         check({width > 7, width <= 41, calSeen},
               {lng[i], 1'h1, lng[i]});
      end
      send(29'h1c01234, 1'h0, 1'h1);
      check({width > 7, width <= 41, calSeen}, 3'h7);
      check(dacOut[0], 16'h0);
      check(pmuMode[0], 22'h0);
      $display("modes done");
   endtask : t_modes
   task automatic t_apply;
      send(29'hfc05678, 1'h1, 1'h1);
      check({width > 41, width <= 90, calSeen}, 3'h7);
      @(posedge mclk iff applyPulse);
      check(dacOut[0], 16'h5678);
      check(pmuMode[0], 22'h388080);
      check(dacOut[1], 16'h0);
      send(29'h1c00abc, 1'h1, 1'h1);
      repeat (6) @(posedge mclk);
      check(dacOut[0], 16'h5678);
      send(29'h1388080, 1'h1, 1'h1);
      repeat (6) @(posedge mclk);
      check(dacOut[0], 16'h0abc);
      $display("apply done");
   endtask : t_apply
   task automatic t_shared;
      send(29'h2200000, 1'h1, 1'h0);
      repeat (20) @(posedge mclk);
      check(pmuMode[1], 22'h0);
      check(busySeen, 1'h0);
      link.otherHoldN <= 1'h1;
      @(posedge mclk iff applyPulse);
      check(pmuMode[1], 22'h200000);
      check(busySeen, 1'h1);
      $display("shared done");
   endtask : t_shared
   // Pin reset in mid-run: busy held, then cleared modes applied on the load
   task automatic t_pin;
      devResetN <= 1'h0;
      repeat (4) @(posedge mclk);
      check(link.busyOeN, 1'h0);
      devResetN <= 1'h1;
      repeat (30) @(posedge mclk);
      check(link.busyOeN, 1'h1);
      check(pmuMode[1], 22'h0);
      $display("pin done");
   endtask : t_pin
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, badCount);
      if (badCount == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      link.otherHoldN = 1'h1;
      repeat (6) @(posedge mclk);
      check(link.busyOeN, 1'h0);
      rstn <= 1'h1;
      t_modes();
      t_apply();
      t_shared();
      t_pin();
      finish_test();
   end
endmodule : test_busy_load_update_sequencer
